// File: verilog/outbound_route_pkg.sv
// Constants, field positions and types shared by the outbound route header generator
package outbound_route_pkg;

  // ----------------------------------------------------------------
  // Transfer unit layout
  // ----------------------------------------------------------------
  localparam int CMD_W = 16;
  localparam int CMD_PAR_W = 2;
  localparam int AD_W = 64;
  localparam int AD_PAR_W = 8;
  localparam int PROC_ADDR_W = 36;
  localparam int GLOBAL_ADDR_W = 40;
  localparam int MASK_W = 8;
  localparam int SRC_ID_W = 12;
  localparam int STATION_W = 4;
  localparam int UNITS_W = 5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPACE_HI = 35;
  localparam int SPACE_LO = 32;
  localparam int STATION_HI = 39;
  localparam int STATION_LO = 36;
  localparam int LOCAL_SEL_HI = 27;
  localparam int LOCAL_SEL_LO = 26;
  localparam int SUBST_EN_BIT = 25;
  localparam int MASK_DATA_HI = 47;
  localparam int MASK_DATA_LO = 40;
  localparam int MASK_ENABLE_BIT = 8;

  // ----------------------------------------------------------------
  // Space selectors and local selectors
  // ----------------------------------------------------------------
  localparam logic [3:0] ORDINARY_MEMORY_SPACE = 4'hF;
  localparam logic [3:0] LOCAL_CARD_SPACE = 4'h1;
  localparam logic [3:0] REMOTE_INTR_SPACE = 4'h8;
  localparam logic [15:0] AUTO_OVERRIDE_MAP = 16'h02EC;
  localparam logic [1:0] SEL_FIFO = 2'h0;
  localparam logic [1:0] SEL_PARITY = 2'h1;

  // ----------------------------------------------------------------
  // Sequence lengths
  // ----------------------------------------------------------------
  localparam logic [4:0] SHORT_LINE_UNITS = 5'h08;
  localparam logic [4:0] LONG_LINE_UNITS = 5'h10;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_MASK_OFS = 12'h000;
  localparam logic [11:0] REG_CONFIG_OFS = 12'h004;
  localparam logic [11:0] REG_STATUS_OFS = 12'h008;
  localparam logic [11:0] REG_SOURCE_OFS = 12'h00C;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    KIND_READ_REQ = 3'h0,
    KIND_INTERVENTION = 3'h1,
    KIND_INVALIDATE = 3'h2,
    KIND_UNC_READ_RESP = 3'h3,
    KIND_UNC_WRITE = 3'h4,
    KIND_UPDATE = 3'h5,
    KIND_CACHED_READ_RESP = 3'h6,
    KIND_CACHED_WRITE = 3'h7
  } req_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DATA = 2'h1,
    ST_LOCAL_DATA = 2'h2,
    ST_ACK = 2'h3
  } seq_state_t;

endpackage

// File: verilog/outbound_route_header_gen.sv
// Outbound framer: header plus data units with routing fields, local space decode, AXI4-Lite regs
//
// Operation
// - Unit: 16 cmd, 2 parity, 64 data, 8 parity
// - Header units and data units are distinguished
// - One header then zero or more data
// - Header holds global address plus routing bits
// - Read requests send header only
// - Intervention and invalidation send header only
// - Uncached response, write, update: one data
// - Cached line transfers: 8 or 16 data
// - Whole sequence steered by its header
// - Ordinary space routes by address bits 39..36
// - Convert 36-bit address to 40-bit global
// - Decode station into mask bits 47..40
// - Source identifier fills bits 63..52
// - Software writable override mask register
// - Some spaces substitute override mask automatically
// - Continuous substitution until software disables it
// - Source bits never replaced by mask
// - Station address assigned at power-up
// - Local space uses bits 27..26 selector
// - Read 00 disables FIFO, replies acknowledge
// - Write 00 loads mask, enable; FIFO on
// - Read 01 parity off; write 01 loads, on
// - Selector 10 reaches interrupt and monitoring
// - Selector 11 reaches card local bus
// - Address bit 25 enable, data 47..40 mask
`timescale 1ns/1ps
`default_nettype none

module outbound_route_header_gen #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [outbound_route_pkg::SRC_ID_W-1:0] source_id_strap,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_kind,
  input wire logic [outbound_route_pkg::PROC_ADDR_W-1:0] req_addr,
  input wire logic [outbound_route_pkg::CMD_W-1:0] req_cmd,
  input wire logic dat_valid,
  output logic dat_ready,
  input wire logic [outbound_route_pkg::AD_W-1:0] dat_word,
  input wire logic [outbound_route_pkg::CMD_W-1:0] dat_id,
  output logic unit_valid,
  input wire logic unit_ready,
  output logic unit_is_header,
  output logic unit_last,
  output logic [outbound_route_pkg::CMD_W-1:0] unit_cmd,
  output logic [outbound_route_pkg::CMD_PAR_W-1:0] unit_cmd_par,
  output logic [outbound_route_pkg::AD_W-1:0] unit_ad,
  output logic [outbound_route_pkg::AD_PAR_W-1:0] unit_ad_par,
  output logic ack_valid,
  input wire logic ack_ready,
  output logic local_valid,
  output logic local_write,
  output logic [1:0] local_sel,
  output logic [outbound_route_pkg::GLOBAL_ADDR_W-1:0] local_addr,
  output logic [outbound_route_pkg::AD_W-1:0] local_wdata,
  output logic fifo_enable,
  output logic parity_check_enable,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import outbound_route_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [GLOBAL_ADDR_W-1:0] to_global(input logic [PROC_ADDR_W-1:0] pa);
    to_global = {pa[35:32], pa[31:28], 4'h0, pa[27:0]};
  endfunction

  function automatic logic [MASK_W-1:0] station_mask(input logic [STATION_W-1:0] stn);
    logic [MASK_W-1:0] m;
    m = 8'h00;
    m[3'h4 + {1'b0, stn[3:2]}] = 1'b1;
    m[{1'b0, stn[1:0]}] = 1'b1;
    station_mask = m;
  endfunction

  function automatic logic [AD_PAR_W-1:0] ad_parity(input logic [AD_W-1:0] w);
    logic [AD_PAR_W-1:0] p;
    p = 8'h00;
    for (int i = 0; i < AD_PAR_W; i++) begin
      p[i] = ^w[8*i +: 8];
    end
    ad_parity = p;
  endfunction

  function automatic logic [CMD_PAR_W-1:0] cmd_parity(input logic [CMD_W-1:0] c);
    cmd_parity = {^c[15:8], ^c[7:0]};
  endfunction

  function automatic logic [UNITS_W-1:0] units_for(input logic [2:0] k, input logic long_line);
    logic [UNITS_W-1:0] n;
    n = 5'h00;
    case (k)
      KIND_READ_REQ, KIND_INTERVENTION, KIND_INVALIDATE: n = 5'h00;
      KIND_UNC_READ_RESP, KIND_UNC_WRITE, KIND_UPDATE: n = 5'h01;
      default: n = long_line ? LONG_LINE_UNITS : SHORT_LINE_UNITS;
    endcase
    units_for = n;
  endfunction

  // ----------------------------------------------------------------
  // Source identifier capture
  // ----------------------------------------------------------------
  logic [SRC_ID_W-1:0] strap_meta_reg;
  logic [SRC_ID_W-1:0] strap_sync_reg;
  logic [SRC_ID_W-1:0] source_id_reg;
  logic [1:0] settle_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= source_id_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= 2'h0;
      source_id_reg <= '0;
    end else if (settle_reg != STRAP_SETTLE) begin
      settle_reg <= settle_reg + 2'h1;
      source_id_reg <= strap_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Header construction
  // ----------------------------------------------------------------
  logic [GLOBAL_ADDR_W-1:0] req_global;
  logic [3:0] req_space;
  logic use_override;
  logic [MASK_W-1:0] route_mask;
  logic [AD_W-1:0] hdr_ad;
  logic [MASK_W-1:0] override_mask_reg;
  logic subst_enable_reg;
  logic long_line_reg;

  assign req_global = to_global(req_addr);
  assign req_space = req_global[SPACE_HI:SPACE_LO];

  always_comb begin
    use_override = AUTO_OVERRIDE_MAP[req_space];
    if (req_space == ORDINARY_MEMORY_SPACE || req_space == REMOTE_INTR_SPACE) begin
      use_override = subst_enable_reg;
    end
  end

  // Station bits decode unless the override mask is selected
  assign route_mask = use_override ? override_mask_reg :
                      station_mask(req_global[STATION_HI:STATION_LO]);
  // Source field always from the strap, never from the mask
  assign hdr_ad = {source_id_reg, 4'h0, route_mask, req_global};

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  seq_state_t state_reg;
  logic [UNITS_W-1:0] remain_reg;
  logic [GLOBAL_ADDR_W-1:0] hold_addr_reg;
  logic slot_free;
  logic req_take;
  logic dat_take;
  logic is_local;
  logic local_is_write;
  logic local_mask_load;
  logic [MASK_W-1:0] local_mask_data;

  assign slot_free = !unit_valid || unit_ready;
  assign is_local = (req_space == LOCAL_CARD_SPACE);
  assign local_is_write = (req_kind == KIND_UNC_WRITE);
  assign req_ready = (state_reg == ST_IDLE) && slot_free;
  assign dat_ready = (state_reg == ST_LOCAL_DATA) || ((state_reg == ST_DATA) && slot_free);
  assign req_take = req_valid && req_ready;
  assign dat_take = dat_valid && dat_ready;
  assign local_mask_load = dat_take && (state_reg == ST_LOCAL_DATA) &&
                           !hold_addr_reg[LOCAL_SEL_HI];
  assign local_mask_data = dat_word[MASK_DATA_HI:MASK_DATA_LO];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      remain_reg <= 5'h00;
      hold_addr_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_take) begin
            hold_addr_reg <= req_global;
            remain_reg <= units_for(req_kind, long_line_reg);
            if (is_local && local_is_write) begin
              state_reg <= ST_LOCAL_DATA;
            end else if (is_local) begin
              state_reg <= ST_ACK;
            end else if (units_for(req_kind, long_line_reg) != 5'h00) begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (dat_take) begin
            remain_reg <= remain_reg - 5'h01;
            if (remain_reg == 5'h01) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_LOCAL_DATA: begin
          if (dat_take) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ACK: begin
          if (ack_ready) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign ack_valid = (state_reg == ST_ACK);

  // ----------------------------------------------------------------
  // Output unit register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_valid <= 1'b0;
      unit_is_header <= 1'b0;
      unit_last <= 1'b0;
      unit_cmd <= '0;
      unit_cmd_par <= '0;
      unit_ad <= '0;
      unit_ad_par <= '0;
    end else if (req_take && !is_local) begin
      unit_valid <= 1'b1;
      unit_is_header <= 1'b1;
      unit_last <= (units_for(req_kind, long_line_reg) == 5'h00);
      unit_cmd <= req_cmd;
      unit_cmd_par <= cmd_parity(req_cmd);
      unit_ad <= hdr_ad;
      unit_ad_par <= ad_parity(hdr_ad);
    end else if (dat_take && state_reg == ST_DATA) begin
      // Data units carry no routing of their own; they follow the header
      unit_valid <= 1'b1;
      unit_is_header <= 1'b0;
      unit_last <= (remain_reg == 5'h01);
      unit_cmd <= dat_id;
      unit_cmd_par <= cmd_parity(dat_id);
      unit_ad <= dat_word;
      unit_ad_par <= ad_parity(dat_word);
    end else if (unit_ready) begin
      unit_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Local resource port
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_valid <= 1'b0;
      local_write <= 1'b0;
      local_sel <= 2'h0;
      local_addr <= '0;
      local_wdata <= '0;
    end else if (req_take && is_local && !local_is_write &&
                 req_global[LOCAL_SEL_HI]) begin
      local_valid <= 1'b1;
      local_write <= 1'b0;
      local_sel <= req_global[LOCAL_SEL_HI:LOCAL_SEL_LO];
      local_addr <= req_global;
      local_wdata <= '0;
    end else if (dat_take && state_reg == ST_LOCAL_DATA && hold_addr_reg[LOCAL_SEL_HI]) begin
      local_valid <= 1'b1;
      local_write <= 1'b1;
      local_sel <= hold_addr_reg[LOCAL_SEL_HI:LOCAL_SEL_LO];
      local_addr <= hold_addr_reg;
      local_wdata <= dat_word;
    end else begin
      local_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // FIFO and parity control
  // ----------------------------------------------------------------
  logic local_read_take;
  assign local_read_take = req_take && is_local && !local_is_write;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_enable <= 1'b1;
    end else if (local_read_take &&
                 req_global[LOCAL_SEL_HI:LOCAL_SEL_LO] == SEL_FIFO) begin
      fifo_enable <= 1'b0;
    end else if (local_mask_load &&
                 hold_addr_reg[LOCAL_SEL_HI:LOCAL_SEL_LO] == SEL_FIFO) begin
      fifo_enable <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_check_enable <= 1'b1;
    end else if (local_read_take &&
                 req_global[LOCAL_SEL_HI:LOCAL_SEL_LO] == SEL_PARITY) begin
      parity_check_enable <= 1'b0;
    end else if (local_mask_load &&
                 hold_addr_reg[LOCAL_SEL_HI:LOCAL_SEL_LO] == SEL_PARITY) begin
      parity_check_enable <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic axi_wr;
  logic [11:0] wr_ofs;
  logic [11:0] rd_ofs;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign axi_wr = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ofs = 12'(aw_addr_reg);
  assign rd_ofs = 12'(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (axi_wr) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (axi_wr) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (axi_wr) begin
      s_axi_bvalid <= 1'b1;
      if (wr_ofs == REG_MASK_OFS || wr_ofs == REG_CONFIG_OFS) begin
        s_axi_bresp <= RESP_OKAY;
      end else if (wr_ofs == REG_STATUS_OFS || wr_ofs == REG_SOURCE_OFS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Override mask: a local-space write beats a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      override_mask_reg <= MASK_RESET;
      subst_enable_reg <= 1'b0;
    end else if (local_mask_load) begin
      override_mask_reg <= local_mask_data;
      subst_enable_reg <= hold_addr_reg[SUBST_EN_BIT];
    end else if (axi_wr && wr_ofs == REG_MASK_OFS) begin
      if (w_strb_reg[0]) begin
        override_mask_reg <= w_data_reg[MASK_W-1:0];
      end
      if (w_strb_reg[1]) begin
        subst_enable_reg <= w_data_reg[MASK_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_line_reg <= 1'b0;
    end else if (axi_wr && wr_ofs == REG_CONFIG_OFS && w_strb_reg[0]) begin
      long_line_reg <= w_data_reg[0];
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (rd_ofs == REG_MASK_OFS) begin
        s_axi_rdata <= {23'h000000, subst_enable_reg, override_mask_reg};
      end else if (rd_ofs == REG_CONFIG_OFS) begin
        s_axi_rdata <= {31'h00000000, long_line_reg};
      end else if (rd_ofs == REG_STATUS_OFS) begin
        s_axi_rdata <= {27'h0000000, state_reg, ack_valid, parity_check_enable, fifo_enable};
      end else if (rd_ofs == REG_SOURCE_OFS) begin
        s_axi_rdata <= {20'h00000, source_id_reg};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: bench/unit_sink.sv
// Station-side sink model that takes output units, stalling at random when slow
`timescale 1ns/1ps
`default_nettype none
module unit_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic unit_valid,
  output logic unit_ready
);
  logic [4:0] lfsr_reg;
  // Takes every unit of a sequence in order, header first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_reg <= 5'h1F;
      unit_ready <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[3:0], lfsr_reg[4] ^ lfsr_reg[2]};
      unit_ready <= !slow || !unit_valid || lfsr_reg[0];
    end
  end
endmodule
`default_nettype wire

// File: bench/outbound_route_header_gen_sva.sv
// Port assertions for the outbound route header generator
`timescale 1ns/1ps
`default_nettype none
module outbound_route_header_gen_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_kind,
  input wire logic [35:0] req_addr,
  input wire logic unit_valid,
  input wire logic unit_ready,
  input wire logic unit_is_header,
  input wire logic unit_last,
  input wire logic [15:0] unit_cmd,
  input wire logic [1:0] unit_cmd_par,
  input wire logic [63:0] unit_ad,
  input wire logic [7:0] unit_ad_par,
  input wire logic ack_valid,
  input wire logic local_valid,
  input wire logic [1:0] local_sel,
  input wire logic fifo_enable,
  input wire logic parity_check_enable
);
  logic take;
  logic lrd;
  logic [3:0] sp;
  logic [7:0] adp;
  assign take = req_valid && req_ready;
  assign sp = req_addr[31:28];
  assign lrd = take && sp == 4'h1 && req_kind != 3'h4;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      adp[i] = ^unit_ad[8*i +: 8];
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  unit_hold_a: assert property (
    unit_valid && !unit_ready |=> unit_valid && $stable(unit_ad)) else $error("unit moved");
  hdr_next_a: assert property (
    take && sp != 4'h1 |=> unit_valid && unit_is_header) else $error("no header");
  hdr_only_a: assert property (
    take && sp != 4'h1 && req_kind < 3'h3 |=> unit_last) else $error("header not last");
  cmd_par_a: assert property (
    unit_valid |-> unit_cmd_par == {^unit_cmd[15:8], ^unit_cmd[7:0]}) else $error("cmd parity");
  ad_par_a: assert property (
    unit_valid |-> unit_ad_par == adp) else $error("data parity");
  glob_addr_a: assert property (
    unit_valid && unit_is_header |-> unit_ad[31:28] == 4'h0 && unit_ad[51:48] == 4'h0)
    else $error("global address form");
  stn_bits_a: assert property (
    take && sp == 4'hF |=> unit_ad[39:32] == $past(req_addr[35:28])) else $error("station bits");
  route_dec_a: assert property (
    take && sp == 4'h4 |=> unit_ad[47:40] ==
    ((8'h10 << $past(req_addr[35:34])) | (8'h01 << $past(req_addr[33:32]))))
    else $error("route decode");
  fifo_off_a: assert property (
    lrd && req_addr[27:26] == 2'h0 |=> ack_valid && !fifo_enable) else $error("fifo not off");
  par_off_a: assert property (
    lrd && req_addr[27:26] == 2'h1 |=> ack_valid && !parity_check_enable)
    else $error("parity not off");
  local_rd_a: assert property (
    lrd && req_addr[27] |=> local_valid && local_sel == $past(req_addr[27:26]))
    else $error("no local access");
  cover property (lrd);
  cover property (unit_valid && unit_last && !unit_is_header);
  cover property (unit_valid && !unit_ready);
endmodule
bind outbound_route_header_gen outbound_route_header_gen_sva i_sva (
  .aclk, .aresetn, .req_valid, .req_ready, .req_kind, .req_addr, .unit_valid, .unit_ready,
  .unit_is_header, .unit_last, .unit_cmd, .unit_cmd_par, .unit_ad, .unit_ad_par, .ack_valid,
  .local_valid, .local_sel, .fifo_enable, .parity_check_enable
);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the outbound route header generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, req_valid, req_ready, dat_valid, dat_ready, unit_valid, unit_ready, slow;
  logic unit_is_header, unit_last, ack_valid, ack_ready, local_valid, local_write, fifo_enable;
  logic parity_check_enable, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] source_id_strap, s_axi_awaddr, s_axi_araddr;
  logic [2:0] req_kind;
  logic [35:0] req_addr;
  logic [15:0] req_cmd, dat_id, unit_cmd;
  logic [63:0] dat_word, unit_ad, local_wdata;
  logic [1:0] unit_cmd_par, local_sel, s_axi_bresp, s_axi_rresp;
  logic [7:0] unit_ad_par, m_mask;
  logic [39:0] local_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic m_en, m_long;
  logic [81:0] exp_u;
  logic [81:0] expq[$];
  int errors, total_checks;
  outbound_route_header_gen i_outbound_route_header_gen (.*);
  unit_sink i_unit_sink (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk_unit(input logic [81:0] got, input logic [81:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t unit %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge aclk) begin
    ack_ready <= 1'($urandom);
    if (aresetn && unit_valid && unit_ready) begin
      exp_u = expq.size() != 0 ? expq.pop_front() : 'x;
      chk_unit({unit_is_header, unit_last, unit_cmd, unit_ad}, exp_u);
    end
  end
  function automatic logic [7:0] route(input logic [3:0] sp, input logic [3:0] st);
    if (sp inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9} || (sp inside {4'h8, 4'hF} && m_en)) begin
      return m_mask;
    end
    return (8'h10 << st[3:2]) | (8'h01 << st[1:0]);
  endfunction
  function automatic logic [35:0] ra(input logic [3:0] sp);
    return {4'($urandom), sp, 28'($urandom)};
  endfunction
  task automatic send(input int kind, input logic [35:0] a);
    int n;
    logic [15:0] c;
    n = kind < 3 ? 0 : kind < 6 ? 1 : m_long ? 16 : 8;
    c = 16'($urandom);
    req_kind <= 3'(kind);
    req_addr <= a;
    req_cmd <= c;
    req_valid <= 1'b1;
    @(negedge aclk);
    while (!req_ready) @(negedge aclk);
    @(posedge aclk);
    req_valid <= 1'b0;
    if (a[31:28] != 4'h1) begin
      expq.push_back({2'b10 | 2'(n == 0), c, source_id_strap, 4'h0, route(a[31:28], a[35:32]),
                      a[35:28], 4'h0, a[27:0]});
    end
    for (int i = 1; i <= n; i++) begin
      dat_word <= {$urandom, $urandom};
      dat_id <= 16'($urandom);
      dat_valid <= 1'b1;
      @(negedge aclk);
      while (!dat_ready) @(negedge aclk);
      @(posedge aclk);
      if (a[31:28] != 4'h1) expq.push_back({1'b0, 1'(i == n), dat_id, dat_word});
      else if (!a[27]) {m_en, m_mask} = {a[25], dat_word[47:40]};
    end
    dat_valid <= 1'b0;
    if (n == 0) @(posedge aclk);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic da, dw, ta, tw;
    {da, dw} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    chk_val({s_axi_bresp, 32'h0}, {r, 32'h0});
    if (a == 12'h000) {m_en, m_mask} = d[8:0];
    if (a == 12'h004) m_long = d[0];
    @(posedge aclk);
  endtask
  task automatic axr(input logic [11:0] a, input logic [33:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    chk_val({s_axi_rresp, s_axi_rdata}, exp);
    @(posedge aclk);
  endtask
  task automatic flags(input logic [1:0] exp);
    @(negedge aclk);
    chk_val({32'h0, parity_check_enable, fifo_enable}, {32'h0, exp});
    @(posedge aclk);
  endtask
  task automatic results();
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end
  initial begin
    void'($urandom(94457));
    source_id_strap = 12'($urandom);
    {req_valid, dat_valid, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow, ack_ready} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {req_kind, req_addr, req_cmd, dat_word, dat_id, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, m_mask, m_en, m_long, errors, total_checks} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(12'h000, 34'h0);
    axr(12'h00C, {22'h0, source_id_strap});
    axr(12'h008, 34'h3);
    axr(12'h010, 34'h200000000);
    for (int k = 0; k < 8; k++) send(k, ra(4'hF));
    axw(12'h004, 32'h1, 2'h0);
    slow <= 1'b1;
    send(7, ra(4'hF));
    send(6, ra(4'h0));
    for (int e = 0; e < 2; e++) begin
      axw(12'h000, {23'h0, 1'(e), 8'h5A}, 2'h0);
      for (int s = 0; s < 16; s++) if (s != 1) send(3, ra(4'(s)));
    end
    axw(12'h010, 32'h0, 2'h2);
    send(0, {8'h01, 28'h0});
    flags(2'b10);
    send(4, {8'h01, 28'h2000000});
    flags(2'b11);
    axr(12'h000, {25'h0, m_en, m_mask});
    send(0, {8'h01, 28'h4000000});
    flags(2'b01);
    send(4, {8'h01, 28'h4000000});
    flags(2'b11);
    axr(12'h000, {25'h0, m_en, m_mask});
    send(1, ra(4'hF));
    send(0, {8'h01, 28'h8000000});
    send(0, {8'h01, 28'hC000000});
    send(4, {8'h01, 28'hC000000});
    repeat (60) @(posedge aclk);
    chk_val(34'(expq.size()), 34'h0);
    results();
  end
endmodule
`default_nettype wire
